// ==== include/rbs_map.vh ====
// Constants for the reset and brownout sequencer.
// Assumes inclusion by the sequencer design file only.
`ifndef RBS_MAP_VH
`define RBS_MAP_VH

// Sequencer states
`define RBS_ST_HOLD 2'h0
`define RBS_ST_OSC 2'h1
`define RBS_ST_COUNT 2'h2
`define RBS_ST_RUN 2'h3

// Wake-up count after oscillator good, in clocks
`define RBS_WAKE_CYCLES 12'h400
// Oscillator must be seen good this many clocks in a row
`define RBS_OSC_STABLE 8'h10
// Threshold filter length, gives hysteresis in time
`define RBS_BOD_FILTER 4'h8
// Width of each threshold filter counter
`define RBS_FILT_W 4
// Processor fetch address after release
`define RBS_BOOT_ADDR 32'h00000000

`endif

// ==== hdl/rbs_sequencer.v ====
// Chip reset combiner, wake-up timer and two-stage brownout response.
// Assumes analog comparators deliver brownout levels already synchronous to ref_clk,
// and that the flash controller reports init done while in reset.
// Any analog hysteresis is outside; the filters add hysteresis in time.
`include "rbs_map.vh"
`default_nettype none

module rbs_sequencer #(
    parameter WAKE_CYCLES = `RBS_WAKE_CYCLES,
    parameter OSC_STABLE = `RBS_OSC_STABLE,
    parameter BOD_FILTER = `RBS_BOD_FILTER
) (
    // Clock and power-on reset
    input wire ref_clk,
    input wire rst_b,
    // Other reset sources
    input wire extResetPin_b,
    input wire watchdogReset,
    // Brownout comparator levels
    input wire bodIrqLevel,
    input wire bodResetLevel,
    // Status of oscillator and flash
    input wire oscRunning,
    input wire flashInitDone,
    // Interrupt controller enable for brownout
    input wire bodIrqEnable,
    // Chip reset and boot address toward the processor
    output reg chipReset_b_r,
    output reg [31:0] fetchAddr_r,
    // Brownout request, status and reset indication
    output reg bodIrqReq_r,
    output reg cpuBodIrq_r,
    output wire bodStatus_r,
    output reg bodResetActive_r
);

    wire anyReset_b;
    reg sync1_r;
    reg sync2_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [11:0] wakeCnt_r;
    reg [7:0] oscCnt_r;
    // Brownout filter outputs and sequencer conditions
    wire [1:0] bodLevel;
    wire [1:0] filtFlag;
    wire bodRstFlag;
    wire oscStable;
    wire wakeDone;

    // State codes and counter end points
    localparam [1:0] ST_HOLD = `RBS_ST_HOLD;
    localparam [1:0] ST_OSC = `RBS_ST_OSC;
    localparam [1:0] ST_COUNT = `RBS_ST_COUNT;
    localparam [1:0] ST_RUN = `RBS_ST_RUN;
    localparam [7:0] OSC_LAST = OSC_STABLE[7:0];
    localparam [11:0] WAKE_LAST = WAKE_CYCLES[11:0];
    localparam [31:0] BOOT_ADDR = `RBS_BOOT_ADDR;

    // Filter counter shape
    localparam FILT_W = `RBS_FILT_W;
    localparam [FILT_W-1:0] FILT_MAX = BOD_FILTER[FILT_W-1:0];
    localparam [FILT_W-1:0] FILT_ZERO = {FILT_W{1'b0}};
    localparam [FILT_W-1:0] FILT_ONE = {{(FILT_W-1){1'b0}}, 1'b1};

    // Sources OR together; brownout reset overlaps rst_b (power-on) down to 0 V
    assign anyReset_b = rst_b & extResetPin_b & ~watchdogReset & ~bodRstFlag;

    // Filters reset only on power-on reset so a brownout reset holds until its level filters back down to zero
    assign bodLevel = {bodResetLevel, bodIrqLevel};
    assign bodStatus_r = filtFlag[0];
    assign bodRstFlag = filtFlag[1];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_filt
            reg [FILT_W-1:0] cnt_r;
            reg flag_r;
            assign filtFlag[g] = flag_r;
            always @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_r <= FILT_ZERO;
                    flag_r <= 1'b0;
                end else begin
                    // Saturating up/down count; the flag flips only at the ends
                    if (bodLevel[g] && cnt_r != FILT_MAX) begin
                        cnt_r <= cnt_r + FILT_ONE;
                    end else if (!bodLevel[g] && cnt_r != FILT_ZERO) begin
                        cnt_r <= cnt_r - FILT_ONE;
                    end
                    if (cnt_r == FILT_MAX) begin
                        flag_r <= 1'b1;
                    end else if (cnt_r == FILT_ZERO) begin
                        flag_r <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Interrupt request to the controller and its enable-gated copy
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bodIrqReq_r <= 1'b0;
            cpuBodIrq_r <= 1'b0;
        end else begin
            bodIrqReq_r <= bodStatus_r;
            cpuBodIrq_r <= bodStatus_r & bodIrqEnable;
        end
    end

    // Visible copy of the latched brownout reset
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bodResetActive_r <= 1'b0;
        end else begin
            bodResetActive_r <= bodRstFlag;
        end
    end

    // Asynchronous assert, two-flop synchronous release
    always @(posedge ref_clk or negedge anyReset_b) begin
        if (!anyReset_b) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= 1'b1;
            sync2_r <= sync1_r;
        end
    end

    // Counter end points reached
    assign oscStable = (oscCnt_r == OSC_LAST);
    assign wakeDone = (wakeCnt_r == WAKE_LAST);

    // Next state of the wake-up sequence
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_HOLD: begin
                if (sync2_r) begin
                    state_nxt = ST_OSC;
                end
            end
            ST_OSC: begin
                if (oscStable) begin
                    state_nxt = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (wakeDone && flashInitDone && oscRunning) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                // Losing the clock source drops reset again until it is stable and the wake-up count has run again
                if (!oscRunning) begin
                    state_nxt = ST_OSC;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // Sequencer restarts from HOLD on any reset request
    always @(posedge ref_clk or negedge anyReset_b) begin
        if (!anyReset_b) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Oscillator must be seen running for a run of clocks; a drop restarts the run
    always @(posedge ref_clk or negedge anyReset_b) begin
        if (!anyReset_b) begin
            oscCnt_r <= 8'h00;
        end else if (state_r == ST_OSC && oscRunning) begin
            if (!oscStable) begin
                oscCnt_r <= oscCnt_r + 8'h01;
            end
        end else begin
            oscCnt_r <= 8'h00;
        end
    end

    // Fixed wake-up count, started once the oscillator is judged stable
    always @(posedge ref_clk or negedge anyReset_b) begin
        if (!anyReset_b) begin
            wakeCnt_r <= 12'h000;
        end else if (state_r == ST_COUNT) begin
            if (!wakeDone) begin
                wakeCnt_r <= wakeCnt_r + 12'h001;
            end
        end else begin
            wakeCnt_r <= 12'h000;
        end
    end

    // Released only on entry to RUN, after every other register has left reset
    always @(posedge ref_clk or negedge anyReset_b) begin
        if (!anyReset_b) begin
            chipReset_b_r <= 1'b0;
            fetchAddr_r <= BOOT_ADDR;
        end else begin
            chipReset_b_r <= (state_nxt == ST_RUN);
            fetchAddr_r <= BOOT_ADDR;
        end
    end

endmodule // rbs_sequencer
`default_nettype wire

// ==== testbench/rbs_assertions.sv ====
// Checker for the reset and brownout sequencer ports.
// Assumes binding into rbs_sequencer.
`default_nettype none
module rbs_assertions #(parameter int BOD_FILTER = 8) (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic extResetPin_b,
    input wire logic watchdogReset,
    // Levels in
    input wire logic bodIrqLevel,
    input wire logic oscRunning,
    input wire logic flashInitDone,
    // Outputs
    input wire logic chipReset_b_r,
    input wire logic [31:0] fetchAddr_r,
    input wire logic bodIrqReq_r,
    input wire logic cpuBodIrq_r,
    input wire logic bodStatus_r,
    input wire logic bodResetActive_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_pin_reset: assert property (!extResetPin_b |-> !chipReset_b_r)
        else $error("pin reset not applied");
    a_wdog_reset: assert property (watchdogReset |-> !chipReset_b_r)
        else $error("watchdog reset not applied");
    a_bod_reset: assert property (bodResetActive_r |-> !chipReset_b_r)
        else $error("brownout reset not applied");
    a_fetch_zero: assert property (chipReset_b_r |-> fetchAddr_r == 32'h0)
        else $error("fetch address not zero");
    a_irq_gate: assert property (cpuBodIrq_r |-> bodIrqReq_r)
        else $error("cpu irq without request");
    a_rel_ready: assert property ($rose(chipReset_b_r) |-> oscRunning && flashInitDone
        && extResetPin_b && !watchdogReset)
        else $error("release while not ready");
    a_irq_follow: assert property ($rose(bodStatus_r) |=> bodIrqReq_r)
        else $error("irq request late");
    a_glitch_block: assert property (!bodIrqLevel [*8] ##1 bodIrqLevel
        |=> !bodStatus_r [*8])
        else $error("status set too soon");
    a_status_hold: assert property (bodIrqLevel [*8] ##1 !bodIrqLevel
        |=> bodStatus_r [*8])
        else $error("status cleared too soon");
endmodule // rbs_assertions
`default_nettype wire

// ==== testbench/rbs_cpu_model.sv ====
// Processor core and interrupt controller enable model.
// Assumes chip reset from the sequencer clears the enable.
`default_nettype none
module rbs_cpu_model (
    // Clock and chip reset
    input wire logic ref_clk,
    input wire logic chipReset_b,
    // Software enable request
    input wire logic enReq,
    output var logic bodIrqEnable
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge ref_clk or negedge chipReset_b) begin
        if (!chipReset_b)
            bodIrqEnable <= 1'h0;
        else
            bodIrqEnable <= enReq;
    end
endmodule // rbs_cpu_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench for the reset and brownout sequencer.
// Assumes short sim counts for wake-up and oscillator checks.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst_b = 0, pinB = 1, wdog = 0, irqLv = 0, rstLv = 0;
    logic osc = 0, fl = 1, enReq = 0, irqEn, rOut, iReq, cIrq, stat, bRst;
    logic [31:0] fa;
    logic [3:0] rows [3] = '{4'h3, 4'hf, 4'h4};
    int nErrors = 0, checked = 0, i;
    rbs_sequencer #(.WAKE_CYCLES(8), .OSC_STABLE(2), .BOD_FILTER(8)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .extResetPin_b(pinB), .watchdogReset(wdog),
        .bodIrqLevel(irqLv), .bodResetLevel(rstLv), .oscRunning(osc),
        .flashInitDone(fl), .bodIrqEnable(irqEn), .chipReset_b_r(rOut),
        .fetchAddr_r(fa), .bodIrqReq_r(iReq), .cpuBodIrq_r(cIrq),
        .bodStatus_r(stat), .bodResetActive_r(bRst));
    rbs_cpu_model u_cpu (.ref_clk(ref_clk), .chipReset_b(rOut), .enReq(enReq),
        .bodIrqEnable(irqEn));
    task tick(int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            nErrors++;
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task wrapUp;
        $display("errors %0d checks %0d", nErrors, checked);
        if (nErrors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task waitRun;
        for (int k = 0; k < 60 && rOut !== 1'h1; k++) @(posedge ref_clk);
        if (rOut !== 1'h1) begin
            nErrors++;
            wrapUp();
        end
        #2;
    endtask
    initial forever #20 ref_clk = ~ref_clk;
    initial begin
        tick(2);
        rst_b = 1;
        tick(20);
        chk("osc_wait", 0, rOut);
        osc = 1;
        waitRun();
        chk("fetch", 0, fa);
        // Rows: pin_b, watchdog, flash done, chip reset after 30 clocks
        for (i = 0; i < 3; i++) begin
            {pinB, wdog, fl} = rows[i][3:1];
            tick(1);
            chk("src_rst", 0, rOut);
            {pinB, wdog} = 2'h2;
            tick(30);
            chk("held", rows[i][0], rOut);
            fl = 1;
            waitRun();
        end
        irqLv = 1;
        tick(12);
        chk("status", 1, stat);
        chk("irq_req", 1, iReq);
        chk("cpu_off", 0, cIrq);
        enReq = 1;
        tick(3);
        chk("cpu_on", 1, cIrq);
        irqLv = 0;
        tick(4);
        chk("hyst", 1, stat);
        tick(8);
        chk("clear", 0, stat);
        irqLv = 1;
        tick(4);
        irqLv = 0;
        tick(12);
        chk("glitch", 0, stat);
        rstLv = 1;
        tick(11);
        chk("bod_rst", 1, bRst);
        chk("bod_chip", 0, rOut);
        rst_b = 0;
        tick(1);
        chk("por_hold", 0, rOut);
        rstLv = 0;
        rst_b = 1;
        waitRun();
        wrapUp();
    end
endmodule // tb
bind rbs_sequencer rbs_assertions #(.BOD_FILTER(BOD_FILTER)) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .extResetPin_b(extResetPin_b),
    .watchdogReset(watchdogReset), .bodIrqLevel(bodIrqLevel), .oscRunning(oscRunning),
    .flashInitDone(flashInitDone), .chipReset_b_r(chipReset_b_r), .fetchAddr_r(fetchAddr_r),
    .bodIrqReq_r(bodIrqReq_r), .cpuBodIrq_r(cpuBodIrq_r), .bodStatus_r(bodStatus_r),
    .bodResetActive_r(bodResetActive_r));
`default_nettype wire
